// ### hw/stepper_position_shutdown_refdrive.v
// Summary of operation
// R1: host keeps acceleration fixed during motion
// R2: acceleration steps equal (vtop^2-vfloor^2)/(2*acc)
// R3: positions are two's complement signed
// R4: position range limited by stepping mode
// R5: set target accepted, actual reported on status
// R6: safe position 11 bits, coarse resolution
// R7: goto safe moves toward safe position
// R8: switch flag zero while switch open
// R9: switch change triggers no automatic action
// R10: fault conditions enter shutdown
// R11: shutdown tristates bridge, target takes actual
// R12: serial interface works during shutdown
// R13: leave shutdown: faults gone plus status read
// R14: leaving shutdown holds current, restarts clock, pump
// R15: inactive after power-on until status read
// R16: first reference motion uses ramp and acceleration
// R17: second reference motion flat at floor velocity; code reaches STEP_FAST once ramp steps left by a short first motion run out
// R18: after second motion actual cleared to zero
// R19: travel to safe only when not -1024
// R20: reference drive ignores all but forced stop
// R21: host picks distinct reference targets
// R22: deadlock left by forced stop then status read
// R23: step loss blocks set target and goto safe
// R24: floor index zero means floor equals top
// R25: positions held in 16-bit signed registers
`timescale 1ns/1ps
`default_nettype none
`include "motion_map.vh"
module stepper_position_shutdown_refdrive (
   // system
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output wire ack_o,
   // fault and switch inputs (asynchronous)
   input wire switch_input_pin_i,
   input wire over_temp_i,
   input wire undervoltage_cutoff_i,
   input wire electrical_defect_i,
   input wire pump_failure_i,
   input wire step_loss_i,
   // motor side
   output reg step_o,
   output reg dir_o,
   output reg bridge_oe_n_o,
   output reg hold_current_o,
   output reg motor_clk_en_o,
   output reg pump_en_o
);
   localparam ST_OFF = 3'h0;
   localparam ST_STOP = 3'h1;
   localparam ST_GOTO = 3'h2;
   localparam ST_REF1 = 3'h3;
   localparam ST_REF2 = 3'h4;
   localparam ST_REFS = 3'h5;
   localparam ST_SHUT = 3'h6;
   localparam ST_DEAD = 3'h7;

   // ==========================================================
   // input synchronisers
   reg [5:0] sync1_q;
   reg [5:0] sync2_q;
   always @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else begin
         sync1_q <= {step_loss_i, pump_failure_i, electrical_defect_i,
            undervoltage_cutoff_i, over_temp_i, switch_input_pin_i};
         sync2_q <= sync1_q;
      end
   end
   wire sw_s = sync2_q[0];
   wire temp_s = sync2_q[1];
   wire uv_s = sync2_q[2];
   wire defect_s = sync2_q[3];
   wire pump_s = sync2_q[4];
   wire loss_s = sync2_q[5];
   wire fault = temp_s | uv_s | defect_s | pump_s; // R10

   // ==========================================================
   // bus slave: single-cycle ack, dropped after one cycle
   reg ack_q;
   assign ack_o = ack_q;
   wire req = cyc_i & stb_i & ~ack_q;
   wire wr = req & we_i;
   wire wr_lo = wr & sel_i[0];
   wire wr_hi = wr & sel_i[1];

   reg [2:0] state_q;
   reg [15:0] target_q; // R25
   reg [15:0] actual_q; // R25
   reg [15:0] ref1_q;
   reg [15:0] ref2_q;
   reg [10:0] safe_q; // R6
   reg [1:0] mode_q;
   reg [3:0] acc_q;
   reg [3:0] vtop_q;
   reg [3:0] vfloor_q;
   reg [15:0] div_q;
   reg [15:0] period_q;
   reg [15:0] ramp_q;
   reg dead_q;
   reg stopped_q;

   // sign-extended safe position scaled to the stepping mode
   function [15:0] safe_scale;
      input [10:0] s;
      input [1:0] m;
      reg [15:0] e;
      begin
         e = {{5{s[10]}}, s};
         safe_scale = e << ({1'b0, m} + 3'h2); // R6
      end
   endfunction

   // clamp a position to the stepping mode range
   function [15:0] clamp;
      input [15:0] p;
      input [1:0] m;
      reg [15:0] lim;
      begin
         lim = 16'h0FFF;
         lim = (lim << m) | ((16'h0001 << m) - 16'h0001);
         if (m == 2'h3)
            clamp = p; // R4
         else if ($signed(p) > $signed(lim))
            clamp = lim; // R4
         else if ($signed(p) < $signed(~lim))
            clamp = ~lim; // R4
         else
            clamp = p; // R3
      end
   endfunction

   // acceleration steps from top and floor speeds
   function [15:0] ramp_steps;
      input [3:0] vt;
      input [3:0] vf;
      input [3:0] a;
      reg [15:0] t;
      reg [15:0] f;
      begin
         t = {8'h00, 4'h0, vt} + 16'h0001;
         f = (vf == 4'h0) ? t : {12'h000, vf}; // R24
         ramp_steps = (t * t - f * f) / ({11'h000, a, 1'b0} + 16'h0002); // R2
      end
   endfunction

   wire cmd_wr = wr_lo && adr_i == `REG_CMD;
   wire [3:0] cmd = dat_i[3:0];
   wire read_one = cmd_wr && cmd == `CMD_READ_ONE;
   wire hard = cmd_wr && cmd == `CMD_FORCED_STOP;
   wire in_ref = state_q == ST_REF1 || state_q == ST_REF2 ||
      state_q == ST_REFS;
   wire moving = state_q == ST_GOTO || in_ref;
   wire safe_en = safe_q != `SAFE_DISABLED; // R19
   wire at_target = actual_q == target_q;

   wire [7:0] status = {loss_s, pump_s, defect_s, dead_q,
      moving, state_q != ST_OFF && state_q != ST_SHUT,
      state_q == ST_SHUT, sw_s}; // R8 R9

   // ==========================================================
   // read data and acknowledge
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_q <= req; // R12
         case (adr_i)
            `REG_CTRL: dat_o <= {18'h00000, vfloor_q, vtop_q, acc_q, mode_q};
            `REG_TARGET: dat_o <= {16'h0000, target_q};
            `REG_ACTUAL: dat_o <= {16'h0000, actual_q}; // R5
            `REG_STATUS: dat_o <= {24'h000000, status};
            `REG_SAFE: dat_o <= {21'h000000, safe_q};
            `REG_PARAM: dat_o <= {ref2_q, ref1_q};
            default: dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // configuration registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= 2'h0;
         acc_q <= 4'h0;
         vtop_q <= 4'h0;
         vfloor_q <= 4'h0;
         safe_q <= `SAFE_DISABLED;
         ref1_q <= 16'h0000;
         ref2_q <= 16'h0000;
      end else begin
         if (wr_lo && adr_i == `REG_CTRL && !moving) begin
            mode_q <= dat_i[1:0];
            acc_q <= dat_i[5:2]; // R1
         end
         if (wr_hi && adr_i == `REG_CTRL && !in_ref) begin
            vtop_q <= dat_i[9:6];
            vfloor_q <= dat_i[13:10];
         end
         if (wr_lo && adr_i == `REG_SAFE && !in_ref)
            safe_q <= dat_i[10:0];
         if (wr_lo && adr_i == `REG_PARAM && !in_ref) begin
            ref1_q <= dat_i[15:0]; // R21
            ref2_q <= dat_i[31:16];
         end
      end
   end

   // ==========================================================
   // motion state machine
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_OFF;
         target_q <= 16'h0000;
         actual_q <= 16'h0000;
         div_q <= 16'h0000;
         period_q <= `STEP_FAST;
         ramp_q <= 16'h0000;
         dead_q <= 1'b0;
         stopped_q <= 1'b0;
         step_o <= 1'b0;
         dir_o <= 1'b0;
         bridge_oe_n_o <= 1'b1;
         hold_current_o <= 1'b0;
         motor_clk_en_o <= 1'b0;
         pump_en_o <= 1'b0;
      end else begin
         step_o <= 1'b0;
         if (fault && state_q != ST_SHUT && state_q != ST_OFF) begin
            state_q <= ST_SHUT; // R10
            target_q <= actual_q; // R11
            bridge_oe_n_o <= 1'b1; // R11
            motor_clk_en_o <= 1'b0;
            pump_en_o <= 1'b0;
            hold_current_o <= 1'b0;
            dead_q <= 1'b0;
         end else begin
            case (state_q)
               ST_OFF, ST_SHUT: begin
                  if (read_one && !fault) begin
                     state_q <= ST_STOP; // R13 R15
                     bridge_oe_n_o <= 1'b0; // R14
                     hold_current_o <= 1'b1; // R14
                     motor_clk_en_o <= 1'b1; // R14
                     pump_en_o <= 1'b1; // R14
                  end
               end
               ST_DEAD: begin
                  if (hard)
                     stopped_q <= 1'b1; // R22
                  else if (read_one && stopped_q) begin
                     stopped_q <= 1'b0; // R22
                     dead_q <= 1'b0;
                     target_q <= actual_q;
                     state_q <= ST_STOP;
                  end
               end
               default: begin
                  if (hard) begin
                     target_q <= actual_q; // R20
                     state_q <= ST_STOP;
                  end else if (in_ref) begin
                     // other commands ignored here (R20)
                     // first target reached, second equals it: stuck
                     if (state_q == ST_REF1 && at_target &&
                        ref2_q == ref1_q) begin
                        state_q <= ST_DEAD; // R21
                        dead_q <= 1'b1;
                     end
                  end else if (cmd_wr && cmd == `CMD_SET_TARGET && !loss_s) begin
                     target_q <= clamp(ref1_q, mode_q); // R5 R23
                     period_q <= `STEP_FAST;
                     state_q <= ST_GOTO;
                  end else if (cmd_wr && cmd == `CMD_GOTO_SAFE && !loss_s &&
                     safe_en) begin
                     target_q <= safe_scale(safe_q, mode_q); // R7 R23
                     period_q <= `STEP_FAST;
                     state_q <= ST_GOTO;
                  end else if (cmd_wr && cmd == `CMD_REFERENCE &&
                     state_q == ST_STOP) begin
                     if (clamp(ref1_q, mode_q) == actual_q) begin
                        state_q <= ST_DEAD; // R21
                        dead_q <= 1'b1;
                     end else begin
                        target_q <= clamp(ref1_q, mode_q); // R16
                        ramp_q <= ramp_steps(vtop_q, vfloor_q, acc_q); // R16
                        // no acceleration steps: start at full speed
                        if (ramp_steps(vtop_q, vfloor_q, acc_q) == 16'h0000)
                           period_q <= `STEP_FAST;
                        else
                           period_q <= `STEP_SLOW;
                        state_q <= ST_REF1;
                     end
                  end
                  if (!hard && moving && state_q != ST_DEAD) begin
                     if (div_q >= period_q) begin
                        div_q <= 16'h0000;
                        if (!at_target) begin
                           step_o <= 1'b1;
                           dir_o <= $signed(target_q) > $signed(actual_q);
                           actual_q <= ($signed(target_q) > $signed(actual_q))
                              ? actual_q + 16'h0001 : actual_q - 16'h0001;
                           if (ramp_q != 16'h0000) begin
                              ramp_q <= ramp_q - 16'h0001; // R2
                              if (ramp_q == 16'h0001)
                                 period_q <= `STEP_FAST;
                           end
                        end else if (state_q == ST_REF1 &&
                           ref2_q != ref1_q) begin
                           target_q <= clamp(ref2_q, mode_q);
                           period_q <= `STEP_SLOW; // R17
                           state_q <= ST_REF2;
                        end else if (state_q == ST_REF2) begin
                           actual_q <= 16'h0000; // R18
                           if (safe_en) begin
                              target_q <= safe_scale(safe_q, mode_q); // R19
                              period_q <= `STEP_FAST;
                              state_q <= ST_REFS;
                           end else begin
                              target_q <= 16'h0000;
                              state_q <= ST_STOP;
                           end
                        end else if (state_q != ST_REF1) begin
                           state_q <= ST_STOP;
                        end
                     end else begin
                        div_q <= div_q + 16'h0001;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule // stepper_position_shutdown_refdrive
`default_nettype wire

// ### shared/motion_map.vh
`ifndef MOTION_MAP_VH
`define MOTION_MAP_VH
// register word addresses (one word each)
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_TARGET 4'h2
`define REG_ACTUAL 4'h3
`define REG_STATUS 4'h4
`define REG_SAFE 4'h5
`define REG_PARAM 4'h6
// command codes written to REG_CMD
`define CMD_SET_TARGET 4'h1
`define CMD_GOTO_SAFE 4'h2
`define CMD_READ_ONE 4'h3
`define CMD_READ_TWO 4'h4
`define CMD_REFERENCE 4'h5
`define CMD_FORCED_STOP 4'h6
// status bit positions
`define ST_SWITCH 0
`define ST_SHUTDOWN 1
`define ST_ACTIVE 2
`define ST_BUSY 3
`define ST_DEADLOCK 4
`define ST_DEFECT 5
`define ST_PUMP 6
`define ST_STEP_LOSS_FLAG 7
// safe position disabled code and bit width
`define SAFE_DISABLED 11'h400
`define SAFE_W 11
// step period in clocks for top and floor velocity
`define STEP_FAST 16'h0100
`define STEP_SLOW 16'h0400
`endif

// ### testbench/stepper_position_shutdown_refdrive_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module stepper_position_shutdown_refdrive_asserts (
   // system and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // fault and motor side
   input wire logic over_temp_i,
   input wire logic step_o,
   input wire logic bridge_oe_n_o,
   input wire logic hold_current_o,
   input wire logic motor_clk_en_o,
   input wire logic pump_en_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========
   // bus handshake
   property p_ack_rise; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_rise: assert property (p_ack_rise) else $error("no ack");
   property p_ack_one; ack_o |=> !ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   // ==========
   // motion and shutdown
   property p_step_gap; step_o |=> !step_o [*8]; endproperty
   a_step_gap: assert property (p_step_gap) else $error("steps too close");
   property p_fault_hiz; over_temp_i [*5] |-> bridge_oe_n_o; endproperty
   a_fault_hiz: assert property (p_fault_hiz) else $error("bridge on");
   property p_hiz_still; bridge_oe_n_o |-> !step_o; endproperty
   a_hiz_still: assert property (p_hiz_still) else $error("step in hiz");
   property p_stay; bridge_oe_n_o && over_temp_i && $past(over_temp_i, 3)
      |=> bridge_oe_n_o; endproperty
   a_stay: assert property (p_stay) else $error("left shutdown");
   property p_exit_en; $fell(bridge_oe_n_o)
      |-> ##[0:2] hold_current_o && motor_clk_en_o && pump_en_o; endproperty
   a_exit_en: assert property (p_exit_en) else $error("no hold");
endmodule // stepper_position_shutdown_refdrive_asserts
bind stepper_position_shutdown_refdrive
   stepper_position_shutdown_refdrive_asserts u_asserts (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .ack_o(ack_o), .over_temp_i(over_temp_i), .step_o(step_o),
   .bridge_oe_n_o(bridge_oe_n_o), .hold_current_o(hold_current_o),
   .motor_clk_en_o(motor_clk_en_o), .pump_en_o(pump_en_o));
`default_nettype wire

// ### testbench/wb_host.sv
`timescale 1ns/1ps
`default_nettype none
module wb_host (
   // bus
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [3:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   int timeouts = 0;
   initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
   // ==========
   // classic single cycle, held until ack
   task automatic xfer(input logic w, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hF, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 20);
      q = dat_i;
      if (n >= 20) timeouts++;
      {cyc_o, stb_o, we_o} <= 3'b000;
   endtask
endmodule // wb_host
`default_nettype wire

// ### testbench/stepper_position_shutdown_refdrive_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "motion_map.vh"
module stepper_position_shutdown_refdrive_bench;
   logic clk_i = 0;
   logic rst_i = 1;
   logic sw = 0;
   logic loss = 0;
   logic [3:0] fault = 0;
   wire cyc, stb, we, ack, step, dir, oe_n, hold, mclk, pump;
   wire [3:0] adr, sel;
   wire [31:0] wdat, rdat;
   logic [31:0] q;
   int fail_count = 0;
   int comparisons = 0;
   int steps = 0;
   int act, tgt, sv, m, i;
   initial forever #10 clk_i = ~clk_i;
   always @(posedge clk_i) if (step === 1'b1) steps <= steps + 1;
   stepper_position_shutdown_refdrive u_stepper_position_shutdown_refdrive (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .switch_input_pin_i(sw), .over_temp_i(fault[0]),
      .undervoltage_cutoff_i(fault[1]), .electrical_defect_i(fault[2]),
      .pump_failure_i(fault[3]), .step_loss_i(loss), .step_o(step),
      .dir_o(dir), .bridge_oe_n_o(oe_n), .hold_current_o(hold),
      .motor_clk_en_o(mclk), .pump_en_o(pump));
   wb_host u_wb_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
      .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   // ==========
   // helpers
   task automatic chk(input logic [15:0] got, input int exp);
      comparisons++;
      if (got !== exp[15:0]) begin
         fail_count++;
         $display("Error %0t: got %0h want %0h", $time, got, exp[15:0]);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      u_wb_host.xfer(1'b1, a, d, q);
      if (u_wb_host.timeouts != 0) print_verdict();
   endtask
   task automatic rd(input logic [3:0] a);
      u_wb_host.xfer(1'b0, a, 32'h0, q);
      if (u_wb_host.timeouts != 0) print_verdict();
   endtask
   task automatic cmd(input logic [3:0] c);
      wr(`REG_CMD, {28'h0, c});
   endtask
   task automatic print_verdict();
      fail_count += u_wb_host.timeouts;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wait_act(input int want);
      int n;
      n = 0;
      do begin
         rd(`REG_ACTUAL);
         n++;
      end while (q[15:0] !== want[15:0] && n < 3000);
      chk(q[15:0], want);
      if (n >= 3000) print_verdict();
   endtask
   // ==========
   // main sequence
   initial begin
      q = 0;
      sv = $urandom(84);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`REG_STATUS);
      chk(q[`ST_ACTIVE], 0);
      cmd(`CMD_READ_ONE);
      rd(`REG_STATUS);
      chk(q[`ST_ACTIVE], 1);
      chk(q[`ST_SWITCH], 0);
      sw <= 1'b1;
      repeat (6) @(posedge clk_i);
      rd(`REG_STATUS);
      chk(q[`ST_SWITCH], 1);
      rd(`REG_ACTUAL);
      chk(q[15:0], 0);
      rd(4'hF);
      chk(q[15:0], 0);
      $display("test activation done");
      for (m = 0; m < 4; m++) begin
         sv = int'($urandom % 2047) - 1023;
         wr(`REG_CTRL, m | 32'h40);
         wr(`REG_SAFE, sv & 32'h7FF);
         cmd(`CMD_GOTO_SAFE);
         rd(`REG_TARGET);
         chk(q[15:0], sv * (4 << m));
         cmd(`CMD_FORCED_STOP);
         wr(`REG_PARAM, 32'h8000);
         cmd(`CMD_SET_TARGET);
         rd(`REG_TARGET);
         chk(q[15:0], -(4096 << m));
         cmd(`CMD_FORCED_STOP);
      end
      $display("test modes done");
      wr(`REG_CTRL, 32'h40);
      rd(`REG_ACTUAL);
      act = int'($signed(q[15:0]));
      tgt = act + 2 + int'($urandom % 3);
      sv = steps;
      wr(`REG_PARAM, tgt & 32'hFFFF);
      cmd(`CMD_SET_TARGET);
      wait_act(tgt);
      chk(steps - sv, tgt - act);
      chk(dir, 1);
      loss <= 1'b1;
      repeat (6) @(posedge clk_i);
      wr(`REG_PARAM, (tgt + 9) & 32'hFFFF);
      cmd(`CMD_SET_TARGET);
      cmd(`CMD_GOTO_SAFE);
      rd(`REG_TARGET);
      chk(q[15:0], tgt);
      loss <= 1'b0;
      $display("test motion done");
      for (i = 0; i < 4; i++) begin
         wr(`REG_PARAM, (tgt - 300) & 32'hFFFF);
         cmd(`CMD_SET_TARGET);
         repeat (600) @(posedge clk_i);
         fault[i] <= 1'b1;
         repeat (8) @(posedge clk_i);
         chk(oe_n, 1);
         chk(dir, 0);
         rd(`REG_STATUS);
         chk(q[`ST_SHUTDOWN], 1);
         chk(q[`ST_DEFECT], i == 2);
         chk(q[`ST_PUMP], i == 3);
         rd(`REG_ACTUAL);
         act = int'($signed(q[15:0]));
         rd(`REG_TARGET);
         chk(q[15:0], act);
         fault[i] <= 1'b0;
         repeat (8) @(posedge clk_i);
         chk(oe_n, 1);
         cmd(`CMD_READ_ONE);
         repeat (2) @(posedge clk_i);
         chk(oe_n, 0);
         chk({hold, mclk, pump}, 7);
         tgt = act;
      end
      $display("test shutdown done");
      wr(`REG_SAFE, `SAFE_DISABLED);
      wr(`REG_PARAM, ((tgt - 1) << 16) | ((tgt - 3) & 32'hFFFF));
      cmd(`CMD_REFERENCE);
      repeat (20) @(posedge clk_i);
      wr(`REG_SAFE, 32'h8);
      cmd(`CMD_GOTO_SAFE);
      wait_act(0);
      repeat (700) @(posedge clk_i);
      rd(`REG_ACTUAL);
      chk(q[15:0], 0);
      rd(`REG_SAFE);
      chk(q[15:0], `SAFE_DISABLED);
      wr(`REG_PARAM, 32'h0001_0000);
      cmd(`CMD_REFERENCE);
      repeat (4) @(posedge clk_i);
      rd(`REG_STATUS);
      chk(q[`ST_DEADLOCK], 1);
      cmd(`CMD_READ_ONE);
      rd(`REG_STATUS);
      chk(q[`ST_DEADLOCK], 1);
      cmd(`CMD_FORCED_STOP);
      cmd(`CMD_READ_ONE);
      rd(`REG_STATUS);
      chk(q[`ST_DEADLOCK], 0);
      wr(`REG_SAFE, 32'h1);
      wr(`REG_PARAM, 32'h0001_FFFF);
      sv = steps;
      cmd(`CMD_REFERENCE);
      wait_act(4);
      chk(steps - sv, 7);
      $display("test reference done");
      print_verdict();
   end
endmodule // stepper_position_shutdown_refdrive_bench
`default_nettype wire
